// file: src/pin_sync.sv
// Two-flop synchroniser for a group of independent pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int          WIDTH = 1,
  parameter logic [63:0] INIT  = 64'h0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Each bit is a separate level; no word coherence is implied
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r       <= INIT[WIDTH-1:0];
      pin_sync_out <= INIT[WIDTH-1:0];
    end else begin
      meta_r       <= pin_in;
      pin_sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// file: src/sar_conversion_mode_control.sv
// Conversion sequencer, SAR search and speed mode control
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_mode_control
  import sar_ctrl_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_LIMIT_CYC,
  parameter int CAL_LEN    = CAL_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              conversion_start_n,
  input  wire logic              speed_sel,
  input  wire logic              normal_sel_n,
  input  wire logic              power_down_in,
  input  wire logic              code_format_sel,
  input  wire logic              serial_sel,
  input  wire logic              comparator_in,
  output logic                   pos_ground_switch,
  output logic                   neg_ground_switch,
  output logic                   sample_connect,
  output logic                   reference_ground,
  output logic      [CODE_W-1:0] dac_bits,
  output logic                   busy,
  output logic      [CODE_W-1:0] result,
  output logic                   result_stale,
  output logic      [1:0]        conv_mode,
  output logic                   parallel_en,
  output logic                   serial_en
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic              start_d_r;
  logic              start_fall;
  logic              conv_go;
  conv_mode_t        mode_now;

  pin_sync #(
    .WIDTH (SYNC_W),
    .INIT  (64'h1)
  ) u_sync (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .pin_in       ({serial_sel, code_format_sel, power_down_in,
                    normal_sel_n, speed_sel, conversion_start_n}),
    .pin_sync_out (pins_s)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) start_d_r <= 1'b1;
    else     start_d_r <= pins_s[SY_START];
  end

  // Hold instant is the synchronised falling edge of start
  assign start_fall = start_d_r & ~pins_s[SY_START]; // [RULE_02]

  always_comb begin
    if (pins_s[SY_SPEED] && pins_s[SY_NORMAL_N])
      mode_now = MODE_WIDEBAND;                        // [RULE_07]
    else if (pins_s[SY_SPEED])
      mode_now = MODE_FAST;                            // [RULE_07]
    else
      mode_now = MODE_NORMAL;                          // [RULE_07]
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  conv_state_t       st_r;
  conv_mode_t        mode_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [BIT_IDX_W-1:0] idx_r;
  logic [CODE_W-1:0] trial_r;

  // A start while busy or powered down is ignored; the sequence is never restarted
  assign conv_go = start_fall && (st_r == ST_IDLE) && !pins_s[SY_PD]; // [RULE_01] [RULE_16]

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_CAL;                                  // [RULE_14]
      cnt_r <= '0;
    end else begin
      case (st_r)
        ST_CAL: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(CAL_LEN - 1)) st_r <= ST_IDLE; // [RULE_15]
        end
        ST_IDLE: begin
          cnt_r <= '0;
          if (conv_go) st_r <= ST_OPEN_SW;             // [RULE_01]
        end
        ST_OPEN_SW: st_r <= ST_TIE_REF;                // [RULE_03]
        ST_TIE_REF: begin
          // Normal mode spends extra settling, trading rate for no gap limit
          if (mode_r == MODE_NORMAL) st_r <= ST_SETTLE; // [RULE_11]
          else                       st_r <= ST_BITS;   // [RULE_08]
        end
        ST_SETTLE: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(NORMAL_SETTLE_CYC - 1)) st_r <= ST_BITS;
        end
        ST_BITS: if (idx_r == '0) st_r <= ST_CODE;     // [RULE_05]
        ST_CODE: st_r <= ST_IDLE;                      // [RULE_06]
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)          mode_r <= MODE_NORMAL;
    else if (conv_go) mode_r <= mode_now;
  end

  // ----------------------------------------------------------------
  // Switch control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pos_ground_switch <= 1'b1;
      neg_ground_switch <= 1'b1;
      sample_connect    <= 1'b1;
      reference_ground  <= 1'b0;
    end else begin
      // Ground switches open first, then arrays leave the inputs
      pos_ground_switch <= (st_r == ST_IDLE || st_r == ST_CAL) && !conv_go; // [RULE_03]
      neg_ground_switch <= (st_r == ST_IDLE || st_r == ST_CAL) && !conv_go; // [RULE_03]
      sample_connect    <= (st_r == ST_IDLE || st_r == ST_CAL ||
                            st_r == ST_CODE);          // [RULE_03] [RULE_04]
      reference_ground  <= (st_r == ST_OPEN_SW || st_r == ST_TIE_REF ||
                            st_r == ST_SETTLE ||
                            (st_r == ST_BITS && idx_r != '0)); // [RULE_03]
    end
  end

  // ----------------------------------------------------------------
  // Successive approximation
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trial_r <= RESULT_RESET;
      idx_r   <= MSB_IDX;
    end else if (st_r == ST_TIE_REF) begin
      trial_r <= MSB_TRIAL;                            // [RULE_05]
      idx_r   <= MSB_IDX;
    end else if (st_r == ST_BITS) begin
      // Comparator low means the trial overshoots the held charge
      if (!comparator_in) trial_r[idx_r] <= 1'b0;      // [RULE_04] [RULE_05]
      if (idx_r != '0) begin
        trial_r[idx_r - 1'b1] <= 1'b1;                 // [RULE_05]
        idx_r <= idx_r - 1'b1;
      end
    end
  end

  assign dac_bits = trial_r;

  // ----------------------------------------------------------------
  // Result, busy and output port select
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result <= RESULT_RESET;
    end else if (st_r == ST_CODE) begin
      result <= pins_s[SY_FMT] ? (trial_r ^ TWOS_FLIP) : trial_r; // [RULE_17] [RULE_12]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) busy <= 1'b1;                             // [RULE_14]
    else     busy <= (st_r == ST_CAL && cnt_r != CNT_W'(CAL_LEN - 1)) ||
                     conv_go ||
                     (st_r != ST_IDLE && st_r != ST_CAL && st_r != ST_CODE); // [RULE_15] [RULE_19]
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      parallel_en <= 1'b0;
      serial_en   <= 1'b0;
      conv_mode   <= 2'h0;
    end else begin
      parallel_en <= !pins_s[SY_SERIAL];               // [RULE_13]
      serial_en   <= pins_s[SY_SERIAL];                // [RULE_13]
      conv_mode   <= mode_r;
    end
  end

  // ----------------------------------------------------------------
  // Gap timer for fast-mode accuracy
  // ----------------------------------------------------------------
  // Saturates so that the first conversion after reset counts as late
  logic [31:0] gap_r;
  logic        stale_pend_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)                   gap_r <= GAP_SAT;
    else if (conv_go)          gap_r <= '0;
    else if (gap_r != GAP_SAT) gap_r <= gap_r + 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stale_pend_r <= 1'b0;
      result_stale <= 1'b0;
    end else begin
      if (conv_go)
        stale_pend_r <= (mode_now != MODE_NORMAL) &&
                        (gap_r > 32'(IDLE_LIMIT));     // [RULE_09] [RULE_11]
      if (st_r == ST_CODE) result_stale <= stale_pend_r; // [RULE_10]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  localparam int FAST_END = 20;

  a_busy_on_start: assert property (conv_go |=> busy && !pos_ground_switch) // [RULE_19]
    else $error("busy or switch wrong after start");
  a_switch_order: assert property ($fell(pos_ground_switch) |-> sample_connect
                  ##1 (!sample_connect && reference_ground)) // [RULE_03]
    else $error("array switched before ground switch");
  a_fast_length: assert property ((conv_go && mode_now != MODE_NORMAL) |->
                  ##1 busy[*8] ##[11:11] busy ##[1:1] !busy) // [RULE_08]
    else $error("fast conversion length wrong");
  a_normal_length: assert property ((conv_go && mode_now == MODE_NORMAL) |->
                  ##[FAST_END:FAST_END] busy ##[2:2] !busy) // [RULE_11]
    else $error("normal conversion length wrong");
  a_msb_first: assert property (st_r == ST_TIE_REF |=> dac_bits == MSB_TRIAL) // [RULE_05]
    else $error("search did not start at MSB");
  a_code_then_busy: assert property (st_r == ST_CODE |=> !busy &&
                  result == ($past(pins_s[SY_FMT]) ? ($past(trial_r) ^ TWOS_FLIP)
                                                   : $past(trial_r))) // [RULE_06]
    else $error("result not formed before busy fell");
  a_pd_ignore: assert property ((st_r == ST_IDLE && pins_s[SY_PD] && start_fall)
                  |=> !busy && st_r == ST_IDLE) // [RULE_16]
    else $error("start accepted in power-down");
  a_cal_busy: assert property (st_r == ST_CAL && cnt_r != '0 |-> busy) // [RULE_15]
    else $error("busy low during calibration");
  a_mode_decode: assert property ((conv_go && pins_s[SY_SPEED] && !pins_s[SY_NORMAL_N]) |->
                  ##2 conv_mode == MODE_FAST) // [RULE_07]
    else $error("mode decode wrong");
  a_normal_fresh: assert property ((conv_go && mode_now == MODE_NORMAL) |=>
                  !stale_pend_r) // [RULE_11]
    else $error("normal result marked stale");

  c_fast_conv:   cover property (conv_go && mode_now == MODE_WIDEBAND);
  c_normal_conv: cover property (conv_go && mode_now == MODE_NORMAL);
  c_stale:       cover property ($rose(result_stale));
  c_pd_ignored:  cover property (st_r == ST_IDLE && pins_s[SY_PD] && start_fall);

endmodule
`default_nettype wire

// file: src/sar_ctrl_pkg.sv
// Constants and types for the SAR conversion and mode control block
// ----------------------------------------------------------------
// How it works
// (RULE_01) Conversion begins when start goes low after acquisition
// (RULE_02) Hold instant taken from start falling edge
// (RULE_03) Open ground switches, then tie arrays to reference ground
// (RULE_04) Convert the value held at acquisition end
// (RULE_05) Binary search over 16 bits, MSB first
// (RULE_06) Form output code, then drop busy
// (RULE_07) Three modes decoded from the two select pins
// (RULE_08) Fast modes support up to 2 MSPS
// (RULE_09) Fast modes accurate only within 1 ms spacing
// (RULE_10) Host discards first fast result after long gap
// (RULE_11) Normal mode up to 1.5 MSPS, no spacing limit
// (RULE_12) No pipeline latency: result matches latest start
// (RULE_13) Result port selectable as serial or parallel
// (RULE_14) Reset high aborts any conversion in progress
// (RULE_15) Reset release starts calibration with busy high
// (RULE_16) Power-down finishes current conversion, ignores new starts
// (RULE_17) Format pin selects straight binary or twos complement
// (RULE_18) Host waits for busy low and acquisition before starting
// (RULE_19) Busy high from conversion start until result ready
// ----------------------------------------------------------------
package sar_ctrl_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int          CODE_W            = 16;
  localparam int          BIT_IDX_W         = 4;
  localparam int          CLK_MHZ           = 40;
  localparam int          IDLE_LIMIT_US     = 1000;
  localparam int          IDLE_LIMIT_CYC    = IDLE_LIMIT_US * CLK_MHZ;
  localparam int          CAL_CYC           = 64;
  localparam int          NORMAL_SETTLE_CYC = 2;
  localparam int          CNT_W             = 16;
  localparam int          SYNC_W            = 6;

  // ----------------------------------------------------------------
  // Codes and positions
  // ----------------------------------------------------------------
  localparam logic [15:0] MSB_TRIAL         = 16'h8000;
  localparam logic [15:0] RESULT_RESET      = 16'h0000;
  localparam logic [15:0] TWOS_FLIP         = 16'h8000;
  localparam logic [3:0]  MSB_IDX           = 4'hF;
  localparam logic [31:0] GAP_SAT           = 32'hFFFF_FFFF;
  localparam int          SY_START          = 0;
  localparam int          SY_SPEED          = 1;
  localparam int          SY_NORMAL_N       = 2;
  localparam int          SY_PD             = 3;
  localparam int          SY_FMT            = 4;
  localparam int          SY_SERIAL         = 5;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FAST,
    MODE_WIDEBAND
  } conv_mode_t;

  typedef enum logic [2:0] {
    ST_CAL,
    ST_IDLE,
    ST_OPEN_SW,
    ST_TIE_REF,
    ST_SETTLE,
    ST_BITS,
    ST_CODE
  } conv_state_t;

endpackage

// file: verif/host_model.sv
// Host-side model that pulses the conversion start pin
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic sys_clk,
  input  wire logic req,
  input  wire logic rogue,
  input  wire logic busy,
  output logic      conversion_start_n
);
  int n;
  // ------------------------------------------------------------
  // Start pulse
  // ------------------------------------------------------------
  initial begin
    conversion_start_n = 1'h1;
    forever begin
      @(negedge sys_clk);
      // Starting while busy happens only when a scenario asks for it
      if (req && (!busy || rogue)) begin
        conversion_start_n = 1'h0;
        n = 0;
        // Held low until busy answers or 8 cycles pass, so the synchroniser cannot miss it
        while (!busy && n < 8) begin
          @(negedge sys_clk);
          n++;
        end
        @(negedge sys_clk);
        conversion_start_n = 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/sar_conversion_mode_control_tb_top.sv
// Self-checking bench for the SAR conversion and mode control block
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_mode_control_tb_top;
  import sar_ctrl_pkg::*;
  localparam int CAL_TB = 8;
  logic              sys_clk, rst, req, rogue, start_n, speed_sel, normal_sel_n, pd, fmt;
  logic              ser, cmp, pgs, ngs, smp, refg, busy, stale, par_en, ser_en;
  logic [CODE_W-1:0] dac, result, sample, s;
  logic [1:0]        mode;
  logic [1:0]        tbl [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
  logic [15:0]       exp_q [$];
  int                error_cnt, total_checks, seed, n;
  bit                long_gap;

  // Comparator of the held sample against the current trial
  assign cmp = (sample >= dac);

  sar_conversion_mode_control #(.IDLE_LIMIT(50), .CAL_LEN(CAL_TB)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .conversion_start_n(start_n), .speed_sel(speed_sel),
    .normal_sel_n(normal_sel_n), .power_down_in(pd), .code_format_sel(fmt),
    .serial_sel(ser), .comparator_in(cmp), .pos_ground_switch(pgs),
    .neg_ground_switch(ngs), .sample_connect(smp), .reference_ground(refg),
    .dac_bits(dac), .busy(busy), .result(result), .result_stale(stale),
    .conv_mode(mode), .parallel_en(par_en), .serial_en(ser_en)
  );

  host_model host_u (
    .sys_clk(sys_clk), .req(req), .rogue(rogue), .busy(busy), .conversion_start_n(start_n)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (exp !== got) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset;
    rst = 1'h1;
    req = 1'h0;
    cyc(20);
    check("busy in reset", 1'h1, busy);
    check("switches in reset", 4'hE, {pgs, ngs, smp, refg});
    check("result in reset", 16'h0000, result);
    rst = 1'h0;
    n = 0;
    while (busy && n < 40) begin
      cyc(1);
      n++;
    end
    check("cal span ok", 1'h1, n >= CAL_TB - 1 && n <= CAL_TB + 4);
    long_gap = 1'h1;
  endtask

  // One conversion: request, watch the switch order, count busy, compare the code
  task automatic conv(input logic [1:0] sel, input logic f, input logic [15:0] v,
                      input bit rg, input bit pdm);
    logic [15:0] exp_code;
    speed_sel = sel[1];
    normal_sel_n = sel[0];
    fmt = f;
    sample = v;
    ser = v[0];
    exp_code = f ? {~v[15], v[14:0]} : v;
    exp_q.push_back(exp_code);
    req = 1'h1;
    n = 0;
    while (!busy && n < 12) begin
      cyc(1);
      n++;
    end
    req = 1'h0;
    check("switches open first", 3'h1, {pgs, ngs, smp});
    cyc(1);
    check("arrays on ref ground", 2'h1, {smp, refg});
    cyc(1);
    check("msb trial", 16'h8000, dac);
    n = 3;
    while (busy && n < 40) begin
      if (rg) begin
        rogue = (n > 5 && n < 9);
        req = rogue;
      end
      if (n == 4 && pdm) pd = 1'h1;
      cyc(1);
      n++;
    end
    check("busy span", 16'(sel[1] ? 20 : 22), 16'(n));
    check("result code", exp_q.pop_front(), result);
    check("stale flag", sel[1] && long_gap, stale);
    check("mode", sel[1] ? (sel[0] ? 2'h2 : 2'h1) : 2'h0, mode);
    check("port select", {ser, ~ser}, {ser_en, par_en});
    long_gap = 1'h0;
    if (rg) begin
      cyc(10);
      check("busy after refused starts", 1'h0, busy);
    end
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Far beyond the expected run length of under a thousand cycles
  initial begin
    #(25.0 * 20000);
    error_cnt++;
    results();
  end

  initial begin
    seed = 27946;
    {rst, req, rogue, speed_sel, normal_sel_n, pd, fmt, ser} = 8'h80;
    sample = 16'h0000;
    do_reset();
    for (int i = 0; i < 12; i++) begin
      s = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : (i == 2) ? 16'h8000 : 16'($random(seed));
      conv(tbl[i % 4], i[2], s, i == 3, 1'b0);
      cyc(i == 5 ? 150 : 3);
      if (i == 5) long_gap = 1'h1;
    end
    // Power-down raised mid-conversion: that one finishes, later starts are ignored
    conv(2'h2, 1'h0, 16'($random(seed)), 1'b0, 1'b1);
    req = 1'h1;
    n = 0;
    repeat (30) begin
      cyc(1);
      n += busy;
    end
    req = 1'h0;
    cyc(10);
    pd = 1'h0;
    check("busy count in power down", 16'h0000, 16'(n));
    // Reset in mid-conversion aborts it and the next fast result is stale
    req = 1'h1;
    cyc(8);
    do_reset();
    conv(2'h3, 1'h1, 16'($random(seed)), 1'b0, 1'b0);
    results();
  end
endmodule
`default_nettype wire
